// ===== logic/pmg_gateway.sv
// Function
// - Config bits 5:4 enable memory access
// - Config bit 3 picks read or write
// - Base register selects aligned eight-byte block
// - Only whole eight-byte bursts are applied
// - High key unlocks only with 0x62
// - Low key unlocks only with 0x9D
// - Bursts accepted in active, doze, sleep
// - Write applied outside sleep sets flag 5, interrupt; delayed sleep apply sets neither
// - Reading interrupt source clears flags, pin
// - Finished burn sets flag 6, interrupt
// - Reset loads burned parameters into memory
// - Burn counts up; fourth uses defaults
// - Empty storage means factory defaults used
// - Burn counter readable at status 2:0
// - Counter reads zero to four
`timescale 1ns/1ps
module pmg_gateway
  import pmg_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_APPLY_CYC
)
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Interrupt
  output logic interrupt_pin_n,
  // Chip operating mode
  input wire logic [1:0] op_mode,
  // Nonvolatile storage macro
  output logic [6:0] nv_rd_addr,
  input wire logic [7:0] nv_rd_data,
  input wire logic [2:0] nv_count,
  output logic nv_wr_en,
  output logic [6:0] nv_wr_addr,
  output logic [7:0] nv_wr_data,
  output logic nv_count_inc
);
  typedef logic [MEM_BYTES-1:0][7:0] pmg_mem_t;
  typedef logic [BURST_LEN-1:0][7:0] pmg_stage_t;

  typedef struct packed {
    pmg_sys_state_e st;
    logic [6:0] idx;
    logic [31:0] wait_cnt;
    logic req_m;
    logic req_s;
    logic req_p;
    logic stop_m;
    logic stop_s;
    logic stop_p;
    logic ack_t;
    logic [7:0] rdata;
    logic [1:0] mode;
    logic dir;
    logic [7:0] base;
    pmg_stage_t stage;
    logic [BURST_LEN-1:0] got;
    pmg_key_e key;
    logic flag_applied;
    logic flag_burned;
    logic int_n;
    logic nv_we;
    logic [6:0] nv_addr;
    logic [7:0] nv_wd;
    logic nv_inc;
    pmg_mem_t mem;
  } pmg_sys_s;

  pmg_sys_s q;
  pmg_sys_s n;
  logic link_req_tgl;
  logic link_req_we;
  logic [7:0] link_req_addr;
  logic [7:0] link_req_wdata;
  logic link_stop_tgl;
  logic req_ev;
  logic stop_ev;
  logic access_on;
  logic burn_valid;

  // ****************************************
  // Link side
  // ****************************************
  pmg_i2c_link pmg_i2c_link_i (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .req_tgl(link_req_tgl),
    .req_we(link_req_we),
    .req_addr(link_req_addr),
    .req_wdata(link_req_wdata),
    .stop_tgl(link_stop_tgl),
    .ack_tgl(q.ack_t),
    .rdata(q.rdata)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Memory index of one byte in the current eight-byte window
  function automatic logic [6:0] mem_index(input logic [7:0] base, input logic [2:0] ofs);
    return base[6:0] + {4'h0, ofs};
  endfunction

  // Offsets 0-7 reach the window only while access mode is on
  function automatic logic win_hit(input logic on, input logic [7:0] addr);
    return on && (addr < 8'(BURST_LEN));
  endfunction

  // Burst ends when mode and direction are written as zero
  function automatic logic burst_end(input logic [7:0] wdata);
    return wdata[5:3] == 3'h0;
  endfunction

  function automatic logic [7:0] cfg_byte(input logic [1:0] mode, input logic dir);
    return {2'h0, mode, dir, 3'h0};
  endfunction

  function automatic logic [7:0] irq_byte(input logic applied, input logic burned);
    return {1'b0, burned, applied, 5'h00};
  endfunction

  function automatic logic [7:0] status_byte(input logic valid, input logic [2:0] count);
    return {4'h0, valid, count};
  endfunction

  function automatic pmg_mem_t apply_burst(input pmg_mem_t mem, input pmg_stage_t stage,
                                           input logic [7:0] base);
    pmg_mem_t m;
    m = mem;
    for (int i = 0; i < BURST_LEN; i++) begin
      m[mem_index(base, 3'(i))] = stage[i];
    end
    return m;
  endfunction

  // Toggle handshake: link request fields are steady once the toggle is seen
  assign req_ev = q.req_s ^ q.req_p;
  assign stop_ev = q.stop_s ^ q.stop_p;
  assign access_on = (q.mode == MODE_ON);
  assign burn_valid = (nv_count != CNT_ZERO) && (nv_count < CNT_EXHAUST);

  // ****************************************
  // Register file, gateway and burn control
  // ****************************************
  always_comb begin
    n = q;
    n.nv_we = 1'b0;
    n.nv_inc = 1'b0;
    n.req_m = link_req_tgl;
    n.req_s = q.req_m;
    n.req_p = q.req_s;
    n.stop_m = link_stop_tgl;
    n.stop_s = q.stop_m;
    n.stop_p = q.stop_s;

    // ****************************************
    // Requests from the link
    // ****************************************
    if (req_ev) begin
      n.ack_t = ~q.ack_t;
      if (link_req_we) begin
        n.key = PMG_K_NONE;
        if (win_hit(access_on, link_req_addr)) begin
          n.stage[link_req_addr[2:0]] = link_req_wdata;
          n.got[link_req_addr[2:0]] = 1'b1;
        end else if (link_req_addr == ADDR_CFG) begin
          n.mode = link_req_wdata[5:4];
          n.dir = link_req_wdata[3];
          n.got = '0;
          // Termination of a write burst; sleep delays the apply
          if (access_on && !q.dir && burst_end(link_req_wdata) && (&q.got) && q.st == PMG_S_IDLE) begin
            if (op_mode == OPM_SLEEP) begin
              n.st = PMG_S_WAIT;
              n.wait_cnt = 32'(SLEEP_CYC - 1);
            end else begin
              n.mem = apply_burst(q.mem, q.stage, q.base);
              n.flag_applied = 1'b1;
            end
          end
        end else if (link_req_addr == ADDR_BASE) begin
          if (q.key == PMG_K_LO && link_req_wdata == BURN_A_VAL) begin
            n.key = PMG_K_A;
          end else if (q.key == PMG_K_A && link_req_wdata == BURN_B_VAL) begin
            n.key = PMG_K_ARMED;
          end else begin
            n.base = {1'b0, link_req_wdata[6:3], 3'h0};
          end
        end else if (link_req_addr == ADDR_KEY_HI) begin
          if (link_req_wdata == KEY_HI_VAL) begin
            n.key = PMG_K_HI;
          end
        end else if (link_req_addr == ADDR_KEY_LO) begin
          if (q.key == PMG_K_HI && link_req_wdata == KEY_LO_VAL) begin
            n.key = PMG_K_LO;
          end
        end
      end else begin
        if (win_hit(access_on, link_req_addr)) begin
          n.rdata = q.mem[mem_index(q.base, link_req_addr[2:0])];
        end else if (link_req_addr == ADDR_IRQ_SRC) begin
          n.rdata = irq_byte(q.flag_applied, q.flag_burned);
          n.flag_applied = 1'b0;
          n.flag_burned = 1'b0;
        end else if (link_req_addr == ADDR_STATUS) begin
          n.rdata = status_byte(burn_valid, nv_count);
        end else if (link_req_addr == ADDR_CFG) begin
          n.rdata = cfg_byte(q.mode, q.dir);
        end else if (link_req_addr == ADDR_BASE) begin
          n.rdata = q.base;
        end else begin
          n.rdata = 8'h00;
        end
      end
    end

    // ****************************************
    // Burn trigger
    // ****************************************
    // Armed key sequence starts the burn at the STOP
    if (stop_ev && q.key == PMG_K_ARMED) begin
      n.key = PMG_K_NONE;
      if (q.st == PMG_S_IDLE) begin
        n.st = PMG_S_BURN;
        n.idx = '0;
      end
    end

    // ****************************************
    // Load, delayed apply and burn engines
    // ****************************************
    // Hardware events come last so a set beats a read clear
    case (q.st)
      PMG_S_LOAD: begin
        n.mem[q.idx] = burn_valid ? nv_rd_data : FACTORY_FILL;
        n.idx = q.idx + 7'h01;
        if (q.idx == MEM_LAST) begin
          n.st = PMG_S_IDLE;
        end
      end
      PMG_S_IDLE: begin
      end
      PMG_S_WAIT: begin
        n.wait_cnt = q.wait_cnt - 32'h0000_0001;
        if (q.wait_cnt == 32'h0000_0000) begin
          n.mem = apply_burst(q.mem, q.stage, q.base);
          n.st = PMG_S_IDLE;
        end
      end
      PMG_S_BURN: begin
        n.nv_we = 1'b1;
        n.nv_addr = q.idx;
        n.nv_wd = q.mem[q.idx];
        n.idx = q.idx + 7'h01;
        if (q.idx == MEM_LAST) begin
          n.st = PMG_S_IDLE;
          n.nv_inc = (nv_count < CNT_EXHAUST);
          n.flag_burned = 1'b1;
        end
      end
      default: begin
      end
    endcase

    n.int_n = ~(n.flag_applied | n.flag_burned);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.int_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign interrupt_pin_n = q.int_n;
  assign nv_rd_addr = q.idx;
  assign nv_wr_en = q.nv_we;
  assign nv_wr_addr = q.nv_addr;
  assign nv_wr_data = q.nv_wd;
  assign nv_count_inc = q.nv_inc;
endmodule

// ===== logic/pmg_pkg.sv
package pmg_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int SLEEP_APPLY_MS = 30;
  localparam int SLEEP_APPLY_CYC = CLK_HZ / 1000 * SLEEP_APPLY_MS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_SRC = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0d;
  localparam logic [7:0] ADDR_BASE = 8'h0e;
  localparam logic [7:0] ADDR_KEY_HI = 8'hac;
  localparam logic [7:0] ADDR_KEY_LO = 8'had;

  // ****************************************
  // Values and fields
  // ****************************************
  localparam logic [7:0] KEY_HI_VAL = 8'h62;
  localparam logic [7:0] KEY_LO_VAL = 8'h9d;
  localparam logic [7:0] BURN_A_VAL = 8'ha5;
  localparam logic [7:0] BURN_B_VAL = 8'h5a;
  localparam logic [7:0] FACTORY_FILL = 8'h00;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] OPM_SLEEP = 2'h2;
  localparam logic [2:0] CNT_EXHAUST = 3'h4;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam int BURST_LEN = 8;
  localparam int MEM_BYTES = 128;
  localparam logic [6:0] MEM_LAST = 7'h7f;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // Slave address value is arbitrary
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2b;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [2:0] {
    PMG_L_IDLE = 3'h0,
    PMG_L_ADDR = 3'h1,
    PMG_L_AACK = 3'h3,
    PMG_L_RX = 3'h2,
    PMG_L_TX = 3'h6,
    PMG_L_MACK = 3'h7
  } pmg_link_state_e;

  typedef enum logic [1:0] {
    PMG_S_LOAD = 2'h0,
    PMG_S_IDLE = 2'h1,
    PMG_S_BURN = 2'h3,
    PMG_S_WAIT = 2'h2
  } pmg_sys_state_e;

  typedef enum logic [2:0] {
    PMG_K_NONE = 3'h0,
    PMG_K_HI = 3'h1,
    PMG_K_LO = 3'h2,
    PMG_K_A = 3'h3,
    PMG_K_ARMED = 3'h4
  } pmg_key_e;
endpackage

// ===== logic/pmg_i2c_link.sv
`timescale 1ns/1ps
module pmg_i2c_link
  import pmg_pkg::*;
(
  // Clock and reset
  input wire logic link_clk,
  input wire logic sys_rst,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Register access toward the system domain
  output logic req_tgl,
  output logic req_we,
  output logic [7:0] req_addr,
  output logic [7:0] req_wdata,
  output logic stop_tgl,
  input wire logic ack_tgl,
  input wire logic [7:0] rdata
);
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic ack_m;
    logic ack_s;
    logic ack_p;
    pmg_link_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic first;
    logic oe;
    logic req_t;
    logic req_we;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic stop_t;
    logic [7:0] rd;
  } pmg_link_s;

  pmg_link_s q;
  pmg_link_s n;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign rise = q.scl_s & ~q.scl_p;
  assign fall = ~q.scl_s & q.scl_p;
  assign start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

  // ****************************************
  // Byte engine
  // ****************************************
  always_comb begin
    n = q;
    n.scl_m = scl_i;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = sda_i;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    n.ack_m = ack_tgl;
    n.ack_s = q.ack_m;
    n.ack_p = q.ack_s;
    if (q.ack_s != q.ack_p) begin
      n.rd = rdata;
    end
    if (start) begin
      n.st = PMG_L_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
    end else if (stop) begin
      n.st = PMG_L_IDLE;
      n.oe = 1'b0;
      n.stop_t = ~q.stop_t;
    end else begin
      case (q.st)
        PMG_L_ADDR, PMG_L_RX: begin
          if (rise && q.cnt < BYTE_BITS) begin
            n.sh = {q.sh[6:0], q.sda_s};
            n.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == BYTE_BITS) begin
            n.st = PMG_L_AACK;
            n.oe = 1'b1;
            if (q.st == PMG_L_ADDR) begin
              if (q.sh[7:1] != I2C_DEV_ADDR) begin
                n.st = PMG_L_IDLE;
                n.oe = 1'b0;
              end else begin
                n.rw = q.sh[0];
                n.first = ~q.sh[0];
                if (q.sh[0]) begin
                  n.req_t = ~q.req_t;
                  n.req_we = 1'b0;
                  n.req_addr = q.ptr;
                  n.ptr = q.ptr + 8'h01;
                end
              end
            end else if (q.first) begin
              n.ptr = q.sh;
              n.first = 1'b0;
            end else begin
              n.req_t = ~q.req_t;
              n.req_we = 1'b1;
              n.req_addr = q.ptr;
              n.req_wdata = q.sh;
              n.ptr = q.ptr + 8'h01;
            end
          end
        end
        PMG_L_AACK: begin
          if (fall) begin
            n.cnt = '0;
            if (q.rw) begin
              n.sh = q.rd;
              n.oe = ~q.rd[7];
              n.st = PMG_L_TX;
            end else begin
              n.oe = 1'b0;
              n.st = PMG_L_RX;
            end
          end
        end
        PMG_L_TX: begin
          if (fall) begin
            if (q.cnt == LAST_TX_BIT) begin
              n.oe = 1'b0;
              n.st = PMG_L_MACK;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.oe = ~q.sh[6];
              n.cnt = q.cnt + 4'h1;
            end
          end
        end
        PMG_L_MACK: begin
          if (rise) begin
            if (q.sda_s) begin
              n.st = PMG_L_IDLE;
            end else begin
              n.req_t = ~q.req_t;
              n.req_we = 1'b0;
              n.req_addr = q.ptr;
              n.ptr = q.ptr + 8'h01;
            end
          end else if (fall) begin
            n.sh = q.rd;
            n.oe = ~q.rd[7];
            n.cnt = '0;
            n.st = PMG_L_TX;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      // Idle bus levels, so no false edge follows reset
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = q.oe;
  assign req_tgl = q.req_t;
  assign req_we = q.req_we;
  assign req_addr = q.req_addr;
  assign req_wdata = q.req_wdata;
  assign stop_tgl = q.stop_t;
endmodule

// ===== tb/pmg_gateway_assertions.sv
`timescale 1ns/1ps
module pmg_gateway_assertions
  import pmg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched outputs and the burn counter input
  input wire logic interrupt_pin_n,
  input wire logic [6:0] nv_rd_addr,
  input wire logic [2:0] nv_count,
  input wire logic nv_wr_en,
  input wire logic [6:0] nv_wr_addr,
  input wire logic nv_count_inc
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  burn_first_a: assert property ($rose(nv_wr_en) |-> nv_wr_addr == 7'h00)
    else $error("burn does not start at byte 0");
  burn_step_a: assert property (nv_wr_en && $past(nv_wr_en) |-> nv_wr_addr == $past(nv_wr_addr) + 7'h01)
    else $error("burn address skipped");
  burn_len_a: assert property ($fell(nv_wr_en) |-> $past(nv_wr_addr) == MEM_LAST)
    else $error("burn ended early");
  inc_follow_a: assert property ($fell(nv_wr_en) && $past(nv_count) != CNT_EXHAUST |-> $past(nv_count_inc))
    else $error("burn not counted");
  inc_limit_a: assert property (nv_count_inc |-> nv_count < CNT_EXHAUST)
    else $error("counter stepped past four");
  inc_once_a: assert property (nv_count_inc |=> !nv_count_inc [*8])
    else $error("counter stepped twice");
  burn_irq_a: assert property ($fell(nv_wr_en) |-> ##[0:4] !interrupt_pin_n)
    else $error("no interrupt after burn");
  load_step_a: assert property (nv_rd_addr != 7'h00 && nv_rd_addr != MEM_LAST |=>
    nv_rd_addr == $past(nv_rd_addr) + 7'h01)
    else $error("load address skipped");
endmodule

bind pmg_gateway pmg_gateway_assertions pmg_gateway_assertions_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .interrupt_pin_n(interrupt_pin_n), .nv_rd_addr(nv_rd_addr), .nv_count(nv_count), .nv_wr_en(nv_wr_en),
  .nv_wr_addr(nv_wr_addr), .nv_count_inc(nv_count_inc));

// ===== tb/pmg_host_model.sv
`timescale 1ns/1ps
module pmg_host_model (
  // I2C bus
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  localparam time H = 450ns;
  int nak = 0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_out(input logic b);
    sda_low = !b;
    #H scl = 1'b1;
    #H scl = 1'b0;
  endtask

  // Also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H sda_low = 1'b1;
    #H scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #H scl = 1'b1;
    #H sda_low = 1'b0;
    #H;
  endtask

  task automatic wb(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    sda_low = 1'b0;
    #H scl = 1'b1;
    if (sda !== 1'b0) nak++;
    #H scl = 1'b0;
  endtask

  task automatic rb(input logic last, output logic [7:0] d);
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #H scl = 1'b1;
      d[i] = sda;
      #H scl = 1'b0;
    end
    bit_out(last);
  endtask
endmodule

// ===== tb/test_param_memory_gateway_and_burn.sv
`timescale 1ns/1ps
module test_param_memory_gateway_and_burn
  import pmg_pkg::*;
;
  localparam logic [7:0] ADW = {I2C_DEV_ADDR, 1'b0};
  localparam logic [7:0] ADR = {I2C_DEV_ADDR, 1'b1};
  logic sys_clk, sys_rst, link_clk, scl, sda_low, sda_o, sda_oe, interrupt_pin_n, nv_wr_en, nv_count_inc;
  logic [1:0] op_mode;
  logic [2:0] nv_count;
  logic [6:0] nv_rd_addr, nv_wr_addr;
  logic [7:0] nv_wr_data, v;
  logic [7:0] nonvolatile_storage [128];
  logic [7:0] exp_mem [128];
  wire logic sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  wire logic [7:0] nv_rd_data = nonvolatile_storage[nv_rd_addr];
  int n_mismatch = 0;
  int compares = 0;
  int n_wr = 0;

  // ****************************************
  // Clocks, design and storage model
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  pmg_gateway #(.SLEEP_CYC(50)) pmg_gateway_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .interrupt_pin_n(interrupt_pin_n),
    .op_mode(op_mode), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .nv_count(nv_count),
    .nv_wr_en(nv_wr_en), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .nv_count_inc(nv_count_inc));
  pmg_host_model host_i (.scl(scl), .sda_low(sda_low), .sda(sda));

  always @(posedge sys_clk) begin
    if (nv_wr_en) begin
      nonvolatile_storage[nv_wr_addr] <= nv_wr_data;
      n_wr <= n_wr + 1;
    end
    if (nv_count_inc) nv_count <= nv_count + 3'h1;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic rst();
    cyc(1);
    sys_rst = 1'b1;
    cyc(8);
    sys_rst = 1'b0;
    cyc(140);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_i.start();
    host_i.wb(ADW);
    host_i.wb(a);
    host_i.wb(d);
    host_i.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host_i.start();
    host_i.wb(ADW);
    host_i.wb(a);
    host_i.start();
    host_i.wb(ADR);
    host_i.rb(1'b1, d);
    host_i.stop();
  endtask
  task automatic wburst(input logic [7:0] b, input int n);
    wr(ADDR_CFG, 8'h10);
    wr(ADDR_BASE, b);
    host_i.start();
    host_i.wb(ADW);
    host_i.wb(8'h00);
    for (int i = 0; i < n; i++) host_i.wb(b ^ 8'h3c ^ i[7:0]);
    host_i.stop();
    wr(ADDR_CFG, 8'h00);
    if (n == BURST_LEN) for (int i = 0; i < 8; i++) exp_mem[b + i] = b ^ 8'h3c ^ i[7:0];
  endtask
  task automatic rburst(input logic [7:0] b);
    logic [7:0] d;
    wr(ADDR_CFG, 8'h18);
    wr(ADDR_BASE, b);
    host_i.start();
    host_i.wb(ADW);
    host_i.wb(8'h00);
    host_i.start();
    host_i.wb(ADR);
    for (int i = 0; i < 8; i++) begin
      host_i.rb(i == 7, d);
      chk(d, exp_mem[b + i]);
    end
    host_i.stop();
    wr(ADDR_CFG, 8'h00);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    op_mode = 2'h0;
    nv_count = CNT_ZERO;
    for (int i = 0; i < 128; i++) begin
      nonvolatile_storage[i] = 8'hff;
      exp_mem[i] = FACTORY_FILL;
    end
    rst();
    rd(ADDR_STATUS, v);
    chk(v, 8'h00);
    rd(ADDR_CFG, v);
    chk(v, 8'h00);
    rd(ADDR_BASE, v);
    chk(v, 8'h00);
    $display("test reset values done");
    wburst(8'h78, 8);
    cyc(20);
    chk({7'h00, interrupt_pin_n}, 8'h00);
    rd(ADDR_IRQ_SRC, v);
    chk(v, 8'h20);
    cyc(4);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    rd(ADDR_IRQ_SRC, v);
    chk(v, 8'h00);
    rburst(8'h78);
    wburst(8'h00, 4);
    cyc(100);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    rburst(8'h00);
    cyc(1);
    op_mode = OPM_SLEEP;
    wburst(8'h08, 8);
    cyc(60);
    chk({7'h00, interrupt_pin_n}, 8'h01);
    rburst(8'h08);
    cyc(1);
    op_mode = 2'h0;
    $display("test bursts done");
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_KEY_HI, k == 0 ? 8'h61 : KEY_HI_VAL);
      wr(ADDR_KEY_LO, k == 1 ? 8'h9c : KEY_LO_VAL);
      wr(ADDR_BASE, BURN_A_VAL);
      wr(ADDR_BASE, BURN_B_VAL);
      cyc(200);
      chk(n_wr[7:0], k == 2 ? 8'h80 : 8'h00);
    end
    chk({7'h00, interrupt_pin_n}, 8'h00);
    rd(ADDR_IRQ_SRC, v);
    chk(v, 8'h40);
    rd(ADDR_STATUS, v);
    chk(v & 8'h07, 8'h01);
    $display("test burn done");
    rst();
    rburst(8'h78);
    cyc(1);
    nv_count = CNT_EXHAUST;
    for (int i = 0; i < 128; i++) exp_mem[i] = FACTORY_FILL;
    rst();
    rburst(8'h78);
    rd(ADDR_STATUS, v);
    chk(v & 8'h07, 8'h04);
    chk(host_i.nak[7:0], 8'h00);
    $display("test reload done");
    summarize();
  end

  initial begin
    #2400us;
    n_mismatch++;
    summarize();
  end
endmodule
